// File: rtl/dmdi_items.sv
// direct data operation and monitor item bank, addressed by data id
`timescale 1ns/100ps
`default_nettype none
module dmdi_items #(
  parameter int INPUT_W = 32,
  parameter int AUTO_CYC = dmdi_pkg::AUTO_OFF_CYC
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // item access from the serial link decoder
  input wire dmdi_pkg::dmdi_access_type i_access,
  output logic [31:0] o_rdata,
  output logic o_rvalid,
  output logic o_id_error,
  // direct operation side
  input wire logic i_running,
  output dmdi_pkg::dmdi_dir_data_type o_exec_data,
  output dmdi_pkg::dmdi_dir_data_type o_buf_data,
  output logic o_buf_loaded,
  output logic o_start,
  // driver inputs and state
  output logic [INPUT_W-1:0] o_inputs,
  input wire logic [31:0] i_output_state,
  input wire logic [31:0] i_alarm_code,
  input wire logic i_comm_err_valid,
  input wire logic [31:0] i_comm_err_code,
  input wire logic i_wrap_enable,
  input wire logic signed [31:0] i_cmd_pos_abs,
  input wire logic signed [31:0] i_cmd_pos_wrap,
  input wire logic signed [31:0] i_cmd_speed_rpm,
  input wire logic signed [31:0] i_cmd_speed_hz
);

  // ****************************************
  // decode
  // ****************************************
  wire logic wr = i_access.valid & i_access.write;
  wire logic rd = i_access.valid & ~i_access.write;
  wire logic [7:0] id = i_access.id;
  wire logic [31:0] wd = i_access.wdata;
  wire logic signed [31:0] wds = i_access.wdata;
  wire logic w_pos = wr & (id == dmdi_pkg::ID_TARGET_POS);
  wire logic w_spd = wr & (id == dmdi_pkg::ID_RUN_SPEED);
  wire logic w_acc = wr & (id == dmdi_pkg::ID_ACCEL_RATE);
  wire logic w_dec = wr & (id == dmdi_pkg::ID_STOP_DECEL);
  wire logic w_cur = wr & (id == dmdi_pkg::ID_RUN_CURRENT);
  wire logic w_trg = wr & (id == dmdi_pkg::ID_START_TRIGGER);
  wire logic w_fwd = wr & (id == dmdi_pkg::ID_FORWARD_TARGET);
  wire logic w_num = wr & (id == dmdi_pkg::ID_DATA_NUMBER);
  wire logic w_typ = wr & (id == dmdi_pkg::ID_OP_TYPE);
  wire logic w_prim = wr & (id == dmdi_pkg::ID_INCMD_PRIMARY);
  wire logic w_mirr = wr & (id == dmdi_pkg::ID_INCMD_MIRROR);
  wire logic w_auto = wr & (id == dmdi_pkg::ID_INCMD_AUTOCLEAR);

  // ****************************************
  // value limiting
  // ****************************************
  // out-of-range writes saturate, or disable the trigger, rather than fault: the link has no nack
  wire logic signed [31:0] spd_lim =
    (wds > dmdi_pkg::SPEED_MAX) ? dmdi_pkg::SPEED_MAX :
    (wds < dmdi_pkg::SPEED_MIN) ? dmdi_pkg::SPEED_MIN : wds;
  wire logic [31:0] rate_lim =
    (wd < dmdi_pkg::RATE_MIN) ? dmdi_pkg::RATE_MIN :
    (wd > dmdi_pkg::RATE_MAX) ? dmdi_pkg::RATE_MAX : wd;
  wire logic [31:0] cur_lim =
    (wd > dmdi_pkg::CURRENT_MAX) ? dmdi_pkg::CURRENT_MAX : wd;
  wire logic signed [31:0] trg_lim =
    (wds < dmdi_pkg::TRIG_MIN) ? dmdi_pkg::TRIG_DISABLE :
    (wds > dmdi_pkg::TRIG_ALL) ? dmdi_pkg::TRIG_DISABLE : wds;

  // ****************************************
  // direct data sets
  // ****************************************
  dmdi_pkg::dmdi_dir_data_type exec_reg;
  dmdi_pkg::dmdi_dir_data_type exec_next;
  dmdi_pkg::dmdi_dir_data_type buf_reg;
  dmdi_pkg::dmdi_dir_data_type buf_next;
  dmdi_pkg::dmdi_dir_data_type upd;
  logic signed [31:0] trigger_reg;
  logic [31:0] forward_reg;
  logic buf_loaded_reg;
  logic [4:0] seen_reg;
  logic [4:0] seen_next;
  logic start_reg;
  logic start_next;
  // running with forward set steers writes away from the live set
  wire logic to_buf = i_running & forward_reg[0];

  always_comb begin
    upd = to_buf ? buf_reg : exec_reg;
    if (w_pos) begin
      upd.position = wds;
    end
    if (w_spd) begin
      upd.speed = spd_lim;
    end
    if (w_acc) begin
      upd.accel = rate_lim;
    end
    if (w_dec) begin
      upd.decel = rate_lim;
    end
    if (w_cur) begin
      upd.current = cur_lim;
    end
    exec_next = to_buf ? exec_reg : upd;
    buf_next = to_buf ? upd : buf_reg;
  end

  // ****************************************
  // start trigger
  // ****************************************
  wire logic [4:0] seen_set = {w_cur, w_dec, w_acc, w_spd, w_pos};
  wire logic sel_hit =
    (trigger_reg == -32'sd7 && w_num) ||
    (trigger_reg == -32'sd6 && w_typ) ||
    (trigger_reg == -32'sd5 && w_pos) ||
    (trigger_reg == -32'sd4 && w_spd) ||
    (trigger_reg == -32'sd3 && w_acc) ||
    (trigger_reg == -32'sd2 && w_dec) ||
    (trigger_reg == -32'sd1 && w_cur);
  wire logic all_hit = (trigger_reg == dmdi_pkg::TRIG_ALL) &&
    (&(seen_reg | seen_set));

  always_comb begin
    start_next = sel_hit | all_hit;
    seen_next = all_hit ? 5'h00 : (seen_reg | seen_set);
    if (w_trg) begin
      seen_next = 5'h00;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      exec_reg <= '{32'sd0, 32'sd0, dmdi_pkg::RST_RATE,
        dmdi_pkg::RST_RATE, dmdi_pkg::RST_CURRENT};
      buf_reg <= '{32'sd0, 32'sd0, dmdi_pkg::RST_RATE,
        dmdi_pkg::RST_RATE, dmdi_pkg::RST_CURRENT};
      trigger_reg <= dmdi_pkg::TRIG_DISABLE;
      forward_reg <= dmdi_pkg::RST_ZERO;
      seen_reg <= 5'h00;
      start_reg <= 1'b0;
      buf_loaded_reg <= 1'b0;
    end else begin
      exec_reg <= exec_next;
      buf_reg <= buf_next;
      seen_reg <= seen_next;
      start_reg <= start_next;
      if (w_trg) begin
        trigger_reg <= trg_lim;
      end
      if (w_fwd) begin
        forward_reg <= {31'h0, wd[0]};
      end
      // buffer stays marked until operation ends; nothing copies it into the live set
      if (to_buf && (|seen_set)) begin
        buf_loaded_reg <= 1'b1;
      end else if (!i_running) begin
        buf_loaded_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // input commands
  // ****************************************
  logic [INPUT_W-1:0] cmd_reg;
  logic [INPUT_W-1:0] auto_reg;
  localparam int COUNT_W_L = dmdi_pkg::COUNT_W;
  logic [COUNT_W_L-1:0] auto_cnt_reg;
  wire logic [INPUT_W-1:0] wd_in = wd[INPUT_W-1:0];
  wire logic auto_done = (auto_reg != '0) &&
    (auto_cnt_reg == COUNT_W_L'(AUTO_CYC - 1));

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cmd_reg <= '0;
      auto_reg <= '0;
      auto_cnt_reg <= '0;
    end else begin
      if (w_prim || w_mirr) begin
        cmd_reg <= wd_in;
        auto_reg <= '0;
      end else if (w_auto) begin
        cmd_reg <= wd_in;
        // pending bits written again restart, so they still turn off
        auto_reg <= (wd_in & ~cmd_reg) | (wd_in & auto_reg);
        auto_cnt_reg <= '0;
      end else if (auto_done) begin
        cmd_reg <= cmd_reg & ~auto_reg;
        auto_reg <= '0;
      end else if (auto_reg != '0) begin
        auto_cnt_reg <= auto_cnt_reg + 1'b1;
      end
    end
  end

  // ****************************************
  // status capture and read back
  // ****************************************
  logic [31:0] comm_err_reg;
  logic [31:0] rdata_reg;
  logic rvalid_reg;
  logic id_err_reg;
  logic [31:0] rsel;
  logic rhit;

  always_comb begin
    rhit = 1'b1;
    unique case (id)
      dmdi_pkg::ID_TARGET_POS: rsel = exec_reg.position;
      dmdi_pkg::ID_RUN_SPEED: rsel = exec_reg.speed;
      dmdi_pkg::ID_ACCEL_RATE: rsel = exec_reg.accel;
      dmdi_pkg::ID_STOP_DECEL: rsel = exec_reg.decel;
      dmdi_pkg::ID_RUN_CURRENT: rsel = exec_reg.current;
      dmdi_pkg::ID_START_TRIGGER: rsel = trigger_reg;
      dmdi_pkg::ID_FORWARD_TARGET: rsel = forward_reg;
      dmdi_pkg::ID_OUTPUT_STATE: rsel = i_output_state;
      dmdi_pkg::ID_ALARM_CODE: rsel = i_alarm_code;
      dmdi_pkg::ID_COMM_ERROR: rsel = comm_err_reg;
      dmdi_pkg::ID_CMD_POSITION: begin
        rsel = i_wrap_enable ? i_cmd_pos_wrap : i_cmd_pos_abs;
      end
      dmdi_pkg::ID_CMD_SPEED_RPM: rsel = i_cmd_speed_rpm;
      dmdi_pkg::ID_CMD_SPEED_HZ: rsel = i_cmd_speed_hz;
      default: begin
        rsel = dmdi_pkg::RST_ZERO;
        rhit = 1'b0;
      end
    endcase
  end

  // writes to read-only or unknown ids, and reads of write-only ones, flag
  wire logic wr_ok = w_pos | w_spd | w_acc | w_dec | w_cur | w_trg |
    w_fwd | w_num | w_typ | w_prim | w_mirr | w_auto;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      comm_err_reg <= dmdi_pkg::RST_ZERO;
      rdata_reg <= dmdi_pkg::RST_ZERO;
      rvalid_reg <= 1'b0;
      id_err_reg <= 1'b0;
    end else begin
      if (i_comm_err_valid) begin
        comm_err_reg <= i_comm_err_code;
      end
      rvalid_reg <= rd;
      rdata_reg <= rd ? rsel : rdata_reg;
      id_err_reg <= (rd & ~rhit) | (wr & ~wr_ok);
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_rdata = rdata_reg;
  assign o_rvalid = rvalid_reg;
  assign o_id_error = id_err_reg;
  assign o_exec_data = exec_reg;
  assign o_buf_data = buf_reg;
  assign o_buf_loaded = buf_loaded_reg;
  assign o_start = start_reg;
  assign o_inputs = cmd_reg;

endmodule
`default_nettype wire

// File: rtl/dmdi_pkg.sv
// package: item identifiers, field layouts and timing for the direct data items
`default_nettype none
package dmdi_pkg;

  // ****************************************
  // item identifiers (printed data ids)
  // ****************************************
  localparam logic [7:0] ID_TARGET_POS = 8'h2e;
  localparam logic [7:0] ID_RUN_SPEED = 8'h2f;
  localparam logic [7:0] ID_ACCEL_RATE = 8'h30;
  localparam logic [7:0] ID_STOP_DECEL = 8'h31;
  localparam logic [7:0] ID_RUN_CURRENT = 8'h32;
  localparam logic [7:0] ID_START_TRIGGER = 8'h33;
  localparam logic [7:0] ID_FORWARD_TARGET = 8'h34;
  localparam logic [7:0] ID_INCMD_MIRROR = 8'h3a;
  localparam logic [7:0] ID_INCMD_AUTOCLEAR = 8'h3c;
  localparam logic [7:0] ID_INCMD_PRIMARY = 8'h3e;
  localparam logic [7:0] ID_OUTPUT_STATE = 8'h3f;
  localparam logic [7:0] ID_ALARM_CODE = 8'h40;
  localparam logic [7:0] ID_COMM_ERROR = 8'h56;
  localparam logic [7:0] ID_CMD_POSITION = 8'h63;
  localparam logic [7:0] ID_CMD_SPEED_RPM = 8'h64;
  localparam logic [7:0] ID_CMD_SPEED_HZ = 8'h65;
  // items selected by trigger codes -7 and -6, in code order
  localparam logic [7:0] ID_DATA_NUMBER = 8'h2c;
  localparam logic [7:0] ID_OP_TYPE = 8'h2d;

  // ****************************************
  // value limits
  // ****************************************
  localparam logic signed [31:0] SPEED_MAX = 32'sh003d_0900;
  localparam logic signed [31:0] SPEED_MIN = -32'sh003d_0900;
  localparam logic [31:0] RATE_MIN = 32'h0000_0001;
  localparam logic [31:0] RATE_MAX = 32'h3b9a_ca00;
  localparam logic [31:0] CURRENT_MAX = 32'h0000_03e8;
  localparam logic signed [31:0] TRIG_MIN = -32'sh0000_0007;
  localparam logic signed [31:0] TRIG_DISABLE = 32'sh0000_0000;
  localparam logic signed [31:0] TRIG_ALL = 32'sh0000_0001;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_RATE = 32'h000f_4240;
  localparam logic [31:0] RST_CURRENT = 32'h0000_03e8;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 10000000;
  localparam int AUTO_OFF_NS = 250000;
  localparam int AUTO_OFF_CYC = AUTO_OFF_NS / (1000000000 / CLK_HZ);
  localparam int COUNT_W = 12;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic signed [31:0] position;
    logic signed [31:0] speed;
    logic [31:0] accel;
    logic [31:0] decel;
    logic [31:0] current;
  } dmdi_dir_data_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] id;
    logic [31:0] wdata;
  } dmdi_access_type;

endpackage
`default_nettype wire

// File: testbench/dmdi_items_asserts.sv
// checker: port-level properties of the direct data item bank
`timescale 1ns/100ps
`default_nettype none
module dmdi_items_asserts #(
  parameter int INPUT_W = 32,
  parameter int AUTO_CYC = 8
) (
  // clock, reset and access
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire dmdi_pkg::dmdi_access_type i_access,
  // answers and state
  input wire logic [31:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic o_id_error,
  input wire logic i_running,
  input wire dmdi_pkg::dmdi_dir_data_type o_exec_data,
  input wire logic [INPUT_W-1:0] o_inputs,
  input wire logic [31:0] i_alarm_code,
  input wire logic i_comm_err_valid,
  input wire logic [31:0] i_comm_err_code
);
  wire logic rd = i_access.valid && !i_access.write;
  wire logic wr = i_access.valid && i_access.write;
  wire logic [7:0] id = i_access.id;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  // hold length fixed at 8 cycles, matching the short sim count
  sequence s_auto_on;
    wr && id == dmdi_pkg::ID_INCMD_AUTOCLEAR && i_access.wdata[0] &&
      !o_inputs[0];
  endsequence
  sequence s_auto_hold;
    o_inputs[0] [*8] ##1 !o_inputs[0];
  endsequence
  sequence s_err;
    i_comm_err_valid ##1 !i_comm_err_valid ##1
      (rd && id == dmdi_pkg::ID_COMM_ERROR && !i_comm_err_valid);
  endsequence
  a_pos_read: assert property (
    rd && id == dmdi_pkg::ID_TARGET_POS |=>
    o_rvalid && o_rdata == $past(o_exec_data.position))
    else $error("position read mismatch");
  a_speed_clamp: assert property (
    wr && id == dmdi_pkg::ID_RUN_SPEED && !i_running &&
    $signed(i_access.wdata) > dmdi_pkg::SPEED_MAX
    |=> o_exec_data.speed == dmdi_pkg::SPEED_MAX)
    else $error("speed not clamped");
  a_primary_set: assert property (
    wr && id == dmdi_pkg::ID_INCMD_PRIMARY
    |=> o_inputs == $past(i_access.wdata[INPUT_W-1:0]))
    else $error("primary command not applied");
  a_wo_refused: assert property (
    rd && id == dmdi_pkg::ID_INCMD_PRIMARY
    |=> o_id_error && o_rdata == 32'h0000_0000)
    else $error("write-only read not refused");
  a_auto_off: assert property (s_auto_on |=> s_auto_hold)
    else $error("auto clear timing wrong");
  a_ro_refused: assert property (
    wr && id == dmdi_pkg::ID_OUTPUT_STATE |=> o_id_error)
    else $error("read-only write not refused");
  a_alarm_read: assert property (
    rd && id == dmdi_pkg::ID_ALARM_CODE |=>
    o_rvalid && o_rdata == $past(i_alarm_code))
    else $error("alarm read mismatch");
  a_err_latch: assert property (
    s_err |=> o_rdata == $past(i_comm_err_code, 3))
    else $error("error code lost");
endmodule
bind dmdi_items dmdi_items_asserts #(
  .INPUT_W(INPUT_W),
  .AUTO_CYC(AUTO_CYC)
) u_chk (
  .i_clk_sys(i_clk_sys),
  .i_resetn(i_resetn),
  .i_access(i_access),
  .o_rdata(o_rdata),
  .o_rvalid(o_rvalid),
  .o_id_error(o_id_error),
  .i_running(i_running),
  .o_exec_data(o_exec_data),
  .o_inputs(o_inputs),
  .i_alarm_code(i_alarm_code),
  .i_comm_err_valid(i_comm_err_valid),
  .i_comm_err_code(i_comm_err_code)
);
`default_nettype wire

// File: testbench/dmdi_host_model.sv
// host model: issues single-cycle item accesses from the link side
`timescale 1ns/100ps
`default_nettype none
module dmdi_host_model (
  input wire logic i_clk_sys,
  output var dmdi_pkg::dmdi_access_type o_access
);
  initial o_access = '0;
  // released fields are inverted so stale ids never look valid
  task automatic acc(input logic w, input logic [7:0] id,
    input logic [31:0] d);
    @(posedge i_clk_sys);
    o_access <= '{1'b1, w, id, d};
    @(posedge i_clk_sys);
    o_access <= '{1'b0, ~w, ~id, ~d};
    @(negedge i_clk_sys);
  endtask
endmodule
`default_nettype wire

// File: testbench/dmdi_items_tb_top.sv
// testbench top: drives the item bank through the host model
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  error_cnt++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module dmdi_items_tb_top;
  logic i_clk_sys = 1'b0;
  logic i_resetn = 1'b0;
  logic run = 1'b0;
  logic err_v = 1'b0;
  logic wrap = 1'b0;
  logic [31:0] out_st = '0, alarm = '0, err_code = '0, pabs = '0;
  logic [31:0] pwrap = '0, rpm = '0, hz = '0, rdata, inputs;
  logic rvalid, id_err, buf_ld, start;
  int error_cnt = 0;
  int check_count = 0;
  dmdi_pkg::dmdi_access_type acc_w;
  dmdi_pkg::dmdi_dir_data_type exec_w, buf_w;
  always #50 i_clk_sys = ~i_clk_sys;
  dmdi_host_model host (.i_clk_sys(i_clk_sys), .o_access(acc_w));
  dmdi_items #(.INPUT_W(32), .AUTO_CYC(8)) DUT (.i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn), .i_access(acc_w), .o_rdata(rdata),
    .o_rvalid(rvalid), .o_id_error(id_err), .i_running(run),
    .o_exec_data(exec_w), .o_buf_data(buf_w), .o_buf_loaded(buf_ld),
    .o_start(start), .o_inputs(inputs), .i_output_state(out_st),
    .i_alarm_code(alarm), .i_comm_err_valid(err_v),
    .i_comm_err_code(err_code), .i_wrap_enable(wrap),
    .i_cmd_pos_abs(pabs), .i_cmd_pos_wrap(pwrap),
    .i_cmd_speed_rpm(rpm), .i_cmd_speed_hz(hz));
  task automatic wr(input logic [7:0] id, input logic [31:0] d);
    host.acc(1'b1, id, d);
  endtask
  task automatic rd(input logic [7:0] id);
    host.acc(1'b0, id, 32'h0);
  endtask
  task automatic wrrd(string n, logic [7:0] id, logic [31:0] d, e);
    wr(id, d);
    rd(id);
    `CHK(n, e, rdata)
  endtask
  task automatic t_ranges;
    rd(dmdi_pkg::ID_ACCEL_RATE);
    `CHK("accel rst", dmdi_pkg::RST_RATE, rdata)
    wrrd("pos min", dmdi_pkg::ID_TARGET_POS,
      32'h8000_0000, 32'h8000_0000);
    wrrd("pos max", dmdi_pkg::ID_TARGET_POS,
      32'h7fff_ffff, 32'h7fff_ffff);
    wrrd("spd hi", dmdi_pkg::ID_RUN_SPEED,
      32'h004c_4b40, dmdi_pkg::SPEED_MAX);
    wrrd("spd lo", dmdi_pkg::ID_RUN_SPEED,
      32'hffb3_b4c0, dmdi_pkg::SPEED_MIN);
    wrrd("acc lo", dmdi_pkg::ID_ACCEL_RATE,
      32'h0, dmdi_pkg::RATE_MIN);
    wrrd("dec hi", dmdi_pkg::ID_STOP_DECEL,
      32'h3b9a_ca01, dmdi_pkg::RATE_MAX);
    wrrd("cur hi", dmdi_pkg::ID_RUN_CURRENT,
      32'h3e9, dmdi_pkg::CURRENT_MAX);
    wrrd("trg bad", dmdi_pkg::ID_START_TRIGGER,
      32'h2, dmdi_pkg::TRIG_DISABLE);
    wrrd("fwd bit", dmdi_pkg::ID_FORWARD_TARGET,
      32'h3, 32'h1);
    $display("ranges done");
  endtask
  task automatic t_trig;
    for (int k = 0; k < 7; k++) begin
      wr(dmdi_pkg::ID_START_TRIGGER, dmdi_pkg::TRIG_MIN + k);
      wr(dmdi_pkg::ID_DATA_NUMBER + 8'(k), 32'h1);
      `CHK("trig code", 1'b1, start)
    end
    wr(dmdi_pkg::ID_TARGET_POS, 32'h2);
    `CHK("other item", 1'b0, start)
    wr(dmdi_pkg::ID_START_TRIGGER, dmdi_pkg::TRIG_DISABLE);
    wr(dmdi_pkg::ID_TARGET_POS, 32'h3);
    `CHK("disabled", 1'b0, start)
    wr(dmdi_pkg::ID_START_TRIGGER, dmdi_pkg::TRIG_ALL);
    for (int k = 0; k < 5; k++) begin
      wr(dmdi_pkg::ID_TARGET_POS + 8'(k), 32'h5);
      `CHK("all data", k == 4, start)
    end
    wr(dmdi_pkg::ID_START_TRIGGER, dmdi_pkg::TRIG_DISABLE);
    $display("trigger done");
  endtask
  task automatic t_fwd;
    @(posedge i_clk_sys) run <= 1'b1;
    wr(dmdi_pkg::ID_FORWARD_TARGET, 32'h1);
    wr(dmdi_pkg::ID_TARGET_POS, 32'h11);
    `CHK("buf pos", 32'h11, buf_w.position)
    `CHK("buf flag", 1'b1, buf_ld)
    `CHK("exec kept", 32'h5, exec_w.position)
    wr(dmdi_pkg::ID_FORWARD_TARGET, 32'h0);
    wr(dmdi_pkg::ID_TARGET_POS, 32'h22);
    `CHK("exec pos", 32'h22, exec_w.position)
    @(posedge i_clk_sys) run <= 1'b0;
    @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    `CHK("buf clear", 1'b0, buf_ld)
    $display("forward done");
  endtask
  task automatic t_inputs;
    wr(dmdi_pkg::ID_INCMD_PRIMARY, 32'ha5);
    `CHK("primary", 32'ha5, inputs)
    wr(dmdi_pkg::ID_INCMD_MIRROR, 32'h5a);
    `CHK("mirror", 32'h5a, inputs)
    wr(dmdi_pkg::ID_INCMD_PRIMARY, 32'h0);
    wr(dmdi_pkg::ID_INCMD_AUTOCLEAR, 32'h1);
    `CHK("auto on", 32'h1, inputs)
    repeat (7) @(negedge i_clk_sys);
    `CHK("auto hold", 32'h1, inputs)
    @(negedge i_clk_sys);
    `CHK("auto off", 32'h0, inputs)
    rd(dmdi_pkg::ID_INCMD_PRIMARY);
    `CHK("wo read", 1'b1, id_err)
    $display("inputs done");
  endtask
  task automatic t_mon;
    @(posedge i_clk_sys);
    out_st <= 32'hc3;
    alarm <= 32'h30;
    pabs <= 32'hffff_fff0;
    pwrap <= 32'h64;
    rpm <= 32'h12c;
    hz <= 32'h3e8;
    err_code <= 32'h84;
    err_v <= 1'b1;
    @(posedge i_clk_sys) err_v <= 1'b0;
    @(posedge i_clk_sys);
    err_code <= 32'h88;
    err_v <= 1'b1;
    @(posedge i_clk_sys) err_v <= 1'b0;
    rd(dmdi_pkg::ID_COMM_ERROR);
    `CHK("comm err", 32'h88, rdata)
    rd(dmdi_pkg::ID_OUTPUT_STATE);
    `CHK("out state", 32'hc3, rdata)
    rd(dmdi_pkg::ID_ALARM_CODE);
    `CHK("alarm", 32'h30, rdata)
    rd(dmdi_pkg::ID_CMD_POSITION);
    `CHK("pos abs", 32'hffff_fff0, rdata)
    @(posedge i_clk_sys) wrap <= 1'b1;
    rd(dmdi_pkg::ID_CMD_POSITION);
    `CHK("pos wrap", 32'h64, rdata)
    rd(dmdi_pkg::ID_CMD_SPEED_RPM);
    `CHK("rpm", 32'h12c, rdata)
    rd(dmdi_pkg::ID_CMD_SPEED_HZ);
    `CHK("hz", 32'h3e8, rdata)
    wr(dmdi_pkg::ID_OUTPUT_STATE, 32'h1);
    `CHK("ro write", 1'b1, id_err)
    rd(8'h10);
    `CHK("unmapped", 1'b1, id_err)
    $display("monitors done");
  endtask
  task automatic t_reset;
    @(posedge i_clk_sys) i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    @(negedge i_clk_sys);
    `CHK("rst inputs", 32'h0, inputs)
    `CHK("rst current", dmdi_pkg::RST_CURRENT, exec_w.current)
    `CHK("rst pos", 32'h0, exec_w.position)
    rd(dmdi_pkg::ID_START_TRIGGER);
    `CHK("rst trigger", dmdi_pkg::TRIG_DISABLE, rdata)
    rd(dmdi_pkg::ID_STOP_DECEL);
    `CHK("rst decel", dmdi_pkg::RST_RATE, rdata)
    $display("reset done");
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // about 160 cycles of traffic; the limit leaves wide margin
  initial begin
    repeat (5000) @(posedge i_clk_sys);
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    t_ranges();
    t_trig();
    t_fwd();
    t_inputs();
    t_mon();
    t_reset();
    give_verdict();
  end
endmodule
`default_nettype wire
